// ### src/ppao_pkg.sv
// constants shared by the port pin block and its helpers
// assumes one 25 MHz clock and a plain strobe register port
//
// Operation
// - deep sleep clamps digital inputs to ground
// - enabled external interrupt pins escape the clamp
// - clamp release sets disabled edge interrupt flags
// - pull-ups stay off while reset is active
// - pull-up follows override, else input-high-enabled
// - driver enable follows override, else direction bit
// - driven level follows override, else output bit
// - toggle override inverts the output bit
// - input-enable override beats the sleep state
// - alternate input taken after the synchroniser, before the pin sample stage
// - analog path taps the synchronised pad, ignoring clamp and enables
// - strobes shared per port, controls per chip
// - global pull-up disable bit kills all pull-ups not under override
// - first port maps interrupts, pin changes, converter
// - direction one drives, zero senses the pin
// - writing one to pin register toggles output
// - pin reads pass a synchroniser delay
package ppao_pkg;
  localparam int PIN_W  = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int EXT_W  = 4;
  localparam int EXT_LSB = 4;
  localparam int CONV_W = 5;
  localparam int SENSE_W = 2;

  localparam logic [ADDR_W-1:0] DIR_ADDR       = 4'h0;
  localparam logic [ADDR_W-1:0] OUT_ADDR       = 4'h1;
  localparam logic [ADDR_W-1:0] PIN_ADDR       = 4'h2;
  localparam logic [ADDR_W-1:0] MCU_CTRL_ADDR  = 4'h3;
  localparam logic [ADDR_W-1:0] PC_STATUS_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] PC_MASK_ADDR   = 4'h5;
  localparam logic [ADDR_W-1:0] EXT_SENSE_ADDR = 4'h6;
  localparam logic [ADDR_W-1:0] EXT_FLAG_ADDR  = 4'h7;
  localparam logic [ADDR_W-1:0] EXT_EN_ADDR    = 4'h8;

  localparam int PUD_BIT        = 4;
  localparam int DBG_DIS_BIT    = 7;
  localparam int VEC_SEL_BIT    = 1;
  localparam int VEC_UNLOCK_BIT = 0;

  localparam logic [DATA_W-1:0] REG_RST        = 8'h00;
  localparam logic [DATA_W-1:0] MCU_CTRL_RST   = 8'h00;
  localparam logic [DATA_W-1:0] MCU_CTRL_WMASK = 8'h93;

  localparam logic [SENSE_W-1:0] SENSE_LOW  = 2'h0;
  localparam logic [SENSE_W-1:0] SENSE_ANY  = 2'h1;
  localparam logic [SENSE_W-1:0] SENSE_FALL = 2'h2;
  localparam logic [SENSE_W-1:0] SENSE_RISE = 2'h3;
endpackage

// ### src/ppao_sync.sv
// three-stage synchroniser for pad levels
// assumes asynchronous pad inputs; output moves when stages 2 and 3 agree
module ppao_sync #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < W; i++)
      begin
        if (stage2[i] == stage3[i])
          dout[i] <= stage3[i];
      end
    end
  end
endmodule

// ### src/ppao_pin_mux.sv
// per-pin override selection, purely combinational
// assumes all inputs share the port clock; results registered by caller
module ppao_pin_mux #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] dirBit,
  input  wire logic [W-1:0] outBit,
  input  wire logic         globalPullupOff,
  input  wire logic         sleepClamp,
  input  wire logic [W-1:0] pullupOverrideEn,
  input  wire logic [W-1:0] pullupOverrideVal,
  input  wire logic [W-1:0] dirOverrideEn,
  input  wire logic [W-1:0] dirOverrideVal,
  input  wire logic [W-1:0] valueOverrideEn,
  input  wire logic [W-1:0] valueOverrideVal,
  input  wire logic [W-1:0] toggleOverrideEn,
  input  wire logic [W-1:0] inputEnOverrideEn,
  input  wire logic [W-1:0] inputEnOverrideVal,
  output logic      [W-1:0] pullupNxt,
  output logic      [W-1:0] driveEnNxt,
  output logic      [W-1:0] driveValNxt,
  output logic      [W-1:0] inputEnNxt
);
  logic [W-1:0] outEff;

  always_comb
  begin
    outEff = outBit ^ toggleOverrideEn;
    pullupNxt = (pullupOverrideEn & pullupOverrideVal)
              | (~pullupOverrideEn & ~dirBit & outEff & {W{~globalPullupOff}});
    driveEnNxt = (dirOverrideEn & dirOverrideVal) | (~dirOverrideEn & dirBit);
    driveValNxt = (valueOverrideEn & valueOverrideVal) | (~valueOverrideEn & outEff);
    inputEnNxt = (inputEnOverrideEn & inputEnOverrideVal)
               | (~inputEnOverrideEn & {W{~sleepClamp}});
  end
endmodule

// ### src/ppao_port_top.sv
// first port pin logic with alternate-function overrides and registers
// assumes strobes one cycle long on ref_clk; pads resolved by the bench
//
// The address map and strobed register access were decided locally.
module ppao_port_top
  import ppao_pkg::*;
(
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [ppao_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [ppao_pkg::DATA_W-1:0]    regWrData,
  input  wire logic                           regWrStrobe,
  input  wire logic                           regRdStrobe,
  output logic      [ppao_pkg::DATA_W-1:0]    regRdData,
  input  wire logic                           sleepClamp,
  input  wire logic [ppao_pkg::PIN_W-1:0]     padIn,
  output logic      [ppao_pkg::PIN_W-1:0]     padOut,
  output logic      [ppao_pkg::PIN_W-1:0]     padOe,
  output logic      [ppao_pkg::PIN_W-1:0]     pullupEn,
  input  wire logic [ppao_pkg::PIN_W-1:0]     pullupOverrideEn,
  input  wire logic [ppao_pkg::PIN_W-1:0]     pullupOverrideVal,
  input  wire logic [ppao_pkg::PIN_W-1:0]     dirOverrideEn,
  input  wire logic [ppao_pkg::PIN_W-1:0]     dirOverrideVal,
  input  wire logic [ppao_pkg::PIN_W-1:0]     valueOverrideEn,
  input  wire logic [ppao_pkg::PIN_W-1:0]     valueOverrideVal,
  input  wire logic [ppao_pkg::PIN_W-1:0]     toggleOverrideEn,
  input  wire logic [ppao_pkg::PIN_W-1:0]     inputEnOverrideEn,
  input  wire logic [ppao_pkg::PIN_W-1:0]     inputEnOverrideVal,
  output logic      [ppao_pkg::PIN_W-1:0]     altDigitalIn,
  output logic      [ppao_pkg::EXT_W-1:0]     extIrqInputs,
  output logic      [ppao_pkg::PIN_W-1:0]     pinChangeSources,
  output logic      [ppao_pkg::CONV_W-1:0]    converterChannels,
  output logic                                debugIfDisable,
  output logic                                vectorTableSelect,
  output logic                                vectorChangeUnlock,
  output logic                                irq
);
  import ppao_pkg::*;

  logic [PIN_W-1:0]         dirR;
  logic [PIN_W-1:0]         outR;
  logic [DATA_W-1:0]        mcuCtrlR;
  logic [PIN_W-1:0]         pcStatusR;
  logic [PIN_W-1:0]         pcMaskR;
  logic [EXT_W*SENSE_W-1:0] extSenseR;
  logic [EXT_W-1:0]         extFlagR;
  logic [EXT_W-1:0]         extEnR;
  logic [PIN_W-1:0]         sampleR;
  logic [PIN_W-1:0]         syncIn;
  logic [PIN_W-1:0]         effInEnOvEn;
  logic [PIN_W-1:0]         effInEnOvVal;
  logic [PIN_W-1:0]         pullupNxt;
  logic [PIN_W-1:0]         driveEnNxt;
  logic [PIN_W-1:0]         driveValNxt;
  logic [PIN_W-1:0]         inputEnNxt;
  logic [PIN_W-1:0]         pcSet;
  logic [EXT_W-1:0]         extSet;
  logic                     globalPullupOff;
  logic [DATA_W-1:0]        rdNxt;

  function automatic logic hit(input logic strobe,
                               input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] target);
    hit = strobe && (addr == target);
  endfunction

  function automatic logic senseHit(input logic [SENSE_W-1:0] sense,
                                    input logic prev,
                                    input logic cur);
    logic result;
    result = 1'b0;
    unique case (sense)
      SENSE_LOW:  result = ~cur;
      SENSE_ANY:  result = prev ^ cur;
      SENSE_FALL: result = prev & ~cur;
      SENSE_RISE: result = ~prev & cur;
    endcase
    senseHit = result;
  endfunction

  assign globalPullupOff = mcuCtrlR[PUD_BIT];

  // enabled external interrupt keeps its input alive
  always_comb
  begin
    effInEnOvEn  = inputEnOverrideEn;
    effInEnOvVal = inputEnOverrideVal;
    effInEnOvEn[EXT_LSB +: EXT_W]  = inputEnOverrideEn[EXT_LSB +: EXT_W] | extEnR;
    effInEnOvVal[EXT_LSB +: EXT_W] = inputEnOverrideVal[EXT_LSB +: EXT_W] | extEnR;
  end

  // pad levels are asynchronous to ref_clk
  ppao_sync #(
    .W (PIN_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (padIn),
    .dout    (syncIn)
  );

  // peripherals drive the override inputs directly
  ppao_pin_mux #(
    .W (PIN_W)
  ) u_mux (
    .dirBit             (dirR),
    .outBit             (outR),
    .globalPullupOff    (globalPullupOff),
    .sleepClamp         (sleepClamp),
    .pullupOverrideEn   (pullupOverrideEn),
    .pullupOverrideVal  (pullupOverrideVal),
    .dirOverrideEn      (dirOverrideEn),
    .dirOverrideVal     (dirOverrideVal),
    .valueOverrideEn    (valueOverrideEn),
    .valueOverrideVal   (valueOverrideVal),
    .toggleOverrideEn   (toggleOverrideEn),
    .inputEnOverrideEn  (effInEnOvEn),
    .inputEnOverrideVal (effInEnOvVal),
    .pullupNxt          (pullupNxt),
    .driveEnNxt         (driveEnNxt),
    .driveValNxt        (driveValNxt),
    .inputEnNxt         (inputEnNxt)
  );

  // direction register, one strobe per port
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      dirR <= REG_RST;
    else if (hit(regWrStrobe, regAddr, DIR_ADDR))
      dirR <= regWrData;
  end

  // pin register write toggles output bits
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      outR <= REG_RST;
    else if (hit(regWrStrobe, regAddr, OUT_ADDR))
      outR <= regWrData;
    else if (hit(regWrStrobe, regAddr, PIN_ADDR))
      outR <= outR ^ regWrData;
  end

  // control register, reserved bits stay zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      mcuCtrlR <= MCU_CTRL_RST;
    else if (hit(regWrStrobe, regAddr, MCU_CTRL_ADDR))
      mcuCtrlR <= regWrData & MCU_CTRL_WMASK;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pcMaskR   <= REG_RST;
      extSenseR <= REG_RST;
      extEnR    <= '0;
    end
    else
    begin
      if (hit(regWrStrobe, regAddr, PC_MASK_ADDR))
        pcMaskR <= regWrData;
      if (hit(regWrStrobe, regAddr, EXT_SENSE_ADDR))
        extSenseR <= regWrData;
      if (hit(regWrStrobe, regAddr, EXT_EN_ADDR))
        extEnR <= regWrData[EXT_W-1:0];
    end
  end

  // reset forces pull-ups and drivers off at once
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pullupEn <= '0;
      padOe    <= '0;
      padOut   <= '0;
    end
    else
    begin
      pullupEn <= pullupNxt;
      padOe    <= driveEnNxt;
      padOut   <= driveValNxt;
    end
  end

  // clamped level before the port's own sample stage
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      altDigitalIn <= '0;
    else
      altDigitalIn <= syncIn & inputEnNxt;
  end

  // pin sample lags the alternate input by one stage
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sampleR <= '0;
    else
      sampleR <= altDigitalIn;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      extIrqInputs      <= '0;
      pinChangeSources  <= '0;
      converterChannels <= '0;
    end
    else
    begin
      extIrqInputs     <= altDigitalIn[EXT_LSB +: EXT_W];
      pinChangeSources <= altDigitalIn;
      // analog tap ignores clamp and enables
      converterChannels <= syncIn[CONV_W-1:0];
    end
  end

  assign pcSet = altDigitalIn ^ sampleR;

  // edge detectors see the clamp release as a change
  genvar g;
  generate
    for (g = 0; g < EXT_W; g++)
    begin : g_ext
      assign extSet[g] = senseHit(extSenseR[g*SENSE_W +: SENSE_W],
                                  sampleR[EXT_LSB+g],
                                  altDigitalIn[EXT_LSB+g]);
    end
  endgenerate

  // sticky flags: a set in the clearing cycle survives
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pcStatusR <= '0;
      extFlagR  <= '0;
    end
    else
    begin
      pcStatusR <= (pcStatusR & ~({PIN_W{hit(regWrStrobe, regAddr, PC_STATUS_ADDR)}}
                   & regWrData)) | pcSet;
      extFlagR  <= (extFlagR & ~({EXT_W{hit(regWrStrobe, regAddr, EXT_FLAG_ADDR)}}
                   & regWrData[EXT_W-1:0])) | extSet;
    end
  end

  // ext enable doubles as the mask for external flags
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= (|(pcStatusR & pcMaskR)) | (|(extFlagR & extEnR));
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      debugIfDisable     <= 1'b0;
      vectorTableSelect  <= 1'b0;
      vectorChangeUnlock <= 1'b0;
    end
    else
    begin
      debugIfDisable     <= mcuCtrlR[DBG_DIS_BIT];
      vectorTableSelect  <= mcuCtrlR[VEC_SEL_BIT];
      vectorChangeUnlock <= mcuCtrlR[VEC_UNLOCK_BIT];
    end
  end

  always_comb
  begin
    rdNxt = '0;
    unique case (regAddr)
      DIR_ADDR:       rdNxt = dirR;
      OUT_ADDR:       rdNxt = outR;
      PIN_ADDR:       rdNxt = sampleR;
      MCU_CTRL_ADDR:  rdNxt = mcuCtrlR;
      PC_STATUS_ADDR: rdNxt = pcStatusR;
      PC_MASK_ADDR:   rdNxt = pcMaskR;
      EXT_SENSE_ADDR: rdNxt = extSenseR;
      EXT_FLAG_ADDR:  rdNxt = {{(DATA_W-EXT_W){1'b0}}, extFlagR};
      EXT_EN_ADDR:    rdNxt = {{(DATA_W-EXT_W){1'b0}}, extEnR};
      default:        rdNxt = '0;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      regRdData <= '0;
    else if (regRdStrobe)
      regRdData <= rdNxt;
    else
      regRdData <= '0;
  end

  a_sleep_clamp: assert property (@(posedge ref_clk) disable iff (rst)
    sleepClamp |=> (altDigitalIn & ~$past(effInEnOvEn)) == '0)
    else $error("clamped input not low");

  a_irq_pin_open: assert property (@(posedge ref_clk) disable iff (rst)
    (sleepClamp && extEnR[0]) |=> altDigitalIn[EXT_LSB] == $past(syncIn[EXT_LSB]))
    else $error("enabled interrupt pin was clamped");

  a_wake_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (extSenseR[3*SENSE_W +: SENSE_W] == SENSE_RISE && !sampleR[EXT_LSB+3]
     && altDigitalIn[EXT_LSB+3])
    |=> extFlagR[3])
    else $error("clamp release did not set flag");

  a_pullup_reset: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> (pullupEn == '0 && padOe == '0))
    else $error("pull-up or driver on after reset");

  a_pullup_pud: assert property (@(posedge ref_clk) disable iff (rst)
    (globalPullupOff && pullupOverrideEn == '0) |=> pullupEn == '0)
    else $error("pull-up on with global disable");

  a_pullup_plain: assert property (@(posedge ref_clk) disable iff (rst)
    (pullupOverrideEn == '0 && toggleOverrideEn == '0)
    |=> pullupEn == $past(~dirR & outR & {PIN_W{~globalPullupOff}}))
    else $error("pull-up mismatch");

  a_driver_sel: assert property (@(posedge ref_clk) disable iff (rst)
    (dirOverrideEn == '0) |=> padOe == $past(dirR))
    else $error("driver enable not from direction");

  a_value_ovr: assert property (@(posedge ref_clk) disable iff (rst)
    (valueOverrideEn != '0)
    |=> ((padOut ^ $past(valueOverrideVal)) & $past(valueOverrideEn)) == '0)
    else $error("override value not driven");

  a_toggle_ovr: assert property (@(posedge ref_clk) disable iff (rst)
    (toggleOverrideEn != '0)
    |=> ((padOut ^ $past(outR ^ toggleOverrideEn)) & ~$past(valueOverrideEn)) == '0)
    else $error("toggle override wrong");

  a_pin_toggle: assert property (@(posedge ref_clk) disable iff (rst)
    hit(regWrStrobe, regAddr, PIN_ADDR) |=> outR == $past(outR ^ regWrData))
    else $error("pin write did not toggle");

  a_read_slot: assert property (@(posedge ref_clk) disable iff (rst)
    hit(regRdStrobe, regAddr, DIR_ADDR) |=> regRdData == $past(dirR))
    else $error("direction read wrong");
endmodule

// ### test/ppao_pad_model.sv
// board model for the port pads: an outside driver plus weak pull-downs
// assumes the bench steers extDrive/extVal and the block drives padOut/padOe
module ppao_pad_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] padOut,
  input  wire logic [W-1:0] padOe,
  input  wire logic [W-1:0] pullupEn,
  input  wire logic [W-1:0] extDrive,
  input  wire logic [W-1:0] extVal,
  output logic      [W-1:0] padLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // block driver wins; an undriven pad without pull-up sinks to the pull-down
  always_comb
  begin
    for (int i = 0; i < W; i++)
      padLevel[i] = padOe[i] ? padOut[i] : (extDrive[i] ? extVal[i] : pullupEn[i]);
  end
endmodule

// ### test/tb_top.sv
// self-checking bench for the first port pin block
// assumes the pad model resolves pads; register bus strobes one cycle long
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ppao_pkg::*;
  logic                ref_clk;
  logic                rst;
  logic [ADDR_W-1:0]   regAddr;
  logic [DATA_W-1:0]   regWrData;
  logic [DATA_W-1:0]   regRdData;
  logic                regWrStrobe;
  logic                regRdStrobe;
  logic                sleepClamp;
  logic [PIN_W-1:0]    padIn, padOut, padOe, pullupEn, altIn, pcSrc;
  logic [PIN_W-1:0]    puEn, puVal, ddEn, ddVal, pvEn, pvVal, ptEn, ieEn, ieVal;
  logic [PIN_W-1:0]    extDrive, extVal;
  logic [EXT_W-1:0]    extIrq;
  logic [CONV_W-1:0]   convCh;
  logic                dbgDis, vecSel, vecUnl, irq;
  int                  fail_count = 0;
  int                  n_compared = 0;
  int                  cycles = 0;

  ppao_port_top u_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(regRdData), .sleepClamp(sleepClamp), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .pullupEn(pullupEn), .pullupOverrideEn(puEn),
    .pullupOverrideVal(puVal), .dirOverrideEn(ddEn), .dirOverrideVal(ddVal),
    .valueOverrideEn(pvEn), .valueOverrideVal(pvVal), .toggleOverrideEn(ptEn),
    .inputEnOverrideEn(ieEn), .inputEnOverrideVal(ieVal), .altDigitalIn(altIn),
    .extIrqInputs(extIrq), .pinChangeSources(pcSrc), .converterChannels(convCh),
    .debugIfDisable(dbgDis), .vectorTableSelect(vecSel),
    .vectorChangeUnlock(vecUnl), .irq(irq));

  ppao_pad_model u_pads (.padOut(padOut), .padOe(padOe), .pullupEn(pullupEn),
    .extDrive(extDrive), .extVal(extVal), .padLevel(padIn));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                     input string nm);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1;
    check(nm, regRdData, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  initial
  begin
    rst = 1'b1;
    regAddr = '0;
    regWrData = '0;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    sleepClamp = 1'b0;
    {puEn, puVal, ddEn, ddVal, pvEn, pvVal, ptEn, ieEn, ieVal} = '0;
    extDrive = '0;
    extVal = '0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    settle(2);
    check("oe after reset", padOe, 8'h00);
    rdc(DIR_ADDR, 8'h00, "dir reset");
    rdc(MCU_CTRL_ADDR, MCU_CTRL_RST, "ctrl reset");
    rdc(4'hf, 8'h00, "unmapped");
    // plain pins, no overrides
    wr(DIR_ADDR, 8'h0f);
    wr(OUT_ADDR, 8'hf5);
    settle(3);
    check("oe", padOe, 8'h0f);
    check("out", padOut & padOe, 8'h05);
    check("pullup", pullupEn, 8'hf0);
    wr(MCU_CTRL_ADDR, 8'hff);
    rdc(MCU_CTRL_ADDR, MCU_CTRL_WMASK, "ctrl rw");
    settle(3);
    check("pull-up off", pullupEn, 8'h00);
    check("ctrl bits", {5'h0, dbgDis, vecSel, vecUnl}, 8'h07);
    wr(MCU_CTRL_ADDR, 8'h00);
    settle(8);
    check("pullup back", pullupEn, 8'hf0);
    rdc(PIN_ADDR, 8'hf5, "pin read");
    check("conv", {3'h0, convCh}, 8'h15);
    check("ext in", {4'h0, extIrq}, 8'h0f);
    check("pc src", pcSrc, 8'hf5);
    // toggle via pin register
    wr(PIN_ADDR, 8'h81);
    rdc(OUT_ADDR, 8'h74, "toggled out");
    puEn <= 8'hff;
    puVal <= 8'h3c;
    ddEn <= 8'hff;
    ddVal <= 8'haa;
    pvEn <= 8'h0f;
    pvVal <= 8'h03;
    settle(3);
    check("pu ovr", pullupEn, 8'h3c);
    check("dir ovr", padOe, 8'haa);
    check("val ovr", padOut & padOe, 8'h22);
    ptEn <= 8'hf0;
    settle(3);
    check("toggle ovr", padOut & padOe, 8'h82);
    {puEn, puVal, ddEn, ddVal, pvEn, pvVal, ptEn} <= '0;
    // inputs driven high from outside, then deep sleep
    wr(DIR_ADDR, 8'h00);
    extDrive <= 8'hff;
    extVal <= 8'hff;
    wr(EXT_EN_ADDR, 8'h01);
    wr(EXT_SENSE_ADDR, {4{SENSE_RISE}});
    ieEn <= 8'h03;
    ieVal <= 8'h01;
    settle(8);
    rdc(PIN_ADDR, 8'hfd, "input disabled");
    sleepClamp <= 1'b1;
    settle(8);
    rdc(PIN_ADDR, 8'h11, "clamped");
    check("alt in", altIn, 8'h11);
    check("conv sleep", {3'h0, convCh}, 8'h1f);
    wr(PC_STATUS_ADDR, 8'hff);
    wr(EXT_FLAG_ADDR, 8'h0f);
    rdc(EXT_FLAG_ADDR, 8'h00, "no fall flags");
    sleepClamp <= 1'b0;
    settle(8);
    rdc(EXT_FLAG_ADDR, 8'h0e, "wake flags");
    // pin 1 stays input-disabled, pins 0 and 4 never clamped
    rdc(PC_STATUS_ADDR, 8'hec, "pc flags");
    check("ext in wake", {4'h0, extIrq}, 8'h0f);
    check("irq masked", {7'h0, irq}, 8'h00);
    wr(PC_MASK_ADDR, 8'h04);
    settle(3);
    check("irq pc", {7'h0, irq}, 8'h01);
    wr(PC_STATUS_ADDR, 8'hff);
    settle(3);
    check("irq pc clr", {7'h0, irq}, 8'h00);
    rdc(PC_STATUS_ADDR, 8'h00, "pc cleared");
    wr(EXT_EN_ADDR, 8'h0f);
    settle(3);
    check("irq ext", {7'h0, irq}, 8'h01);
    wr(EXT_FLAG_ADDR, 8'h0f);
    settle(3);
    check("irq ext clr", {7'h0, irq}, 8'h00);
    // pull-ups dropped by reset
    ieEn <= '0;
    extDrive <= '0;
    wr(OUT_ADDR, 8'hff);
    settle(3);
    check("pullup on", pullupEn, 8'hff);
    rst <= 1'b1;
    settle(1);
    check("pullup in reset", pullupEn, 8'h00);
    rst <= 1'b0;
    settle(3);
    check("pullup after", pullupEn, 8'h00);
    complete_run();
  end
endmodule
